// [hw/fsk_word_output.sv]
// fsk word output interface: carrier gating, serial word port, interrupt, apb registers
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fsk_word_output #(
	parameter int unsigned CD_QUAL_CYCLES    = fsk_pkg::CD_QUAL_CYC,
	parameter int unsigned CD_HOLD_CYCLES    = fsk_pkg::CD_HOLD_CYC,
	parameter int unsigned HALF_BIT_CYCLES   = fsk_pkg::HALF_BIT_CYC,
	parameter int unsigned BIT_CYCLES        = fsk_pkg::BIT_CYC,
	parameter int unsigned TONE_GUARD_CYCLES = fsk_pkg::TONE_GUARD_CYC,
	parameter int unsigned ARR_HOLD_CYCLES   = fsk_pkg::ARR_HOLD_CYC
) (
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [fsk_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        demod_bit,
	input  wire logic                        band_activity,
	input  wire logic                        host_read_clock,
	input  wire logic                        arrival_sense_in,
	input  wire logic                        alert_tone_early,
	output logic                             serial_data,
	output logic                             word_ready_n,
	output logic                             carrier_present_n,
	output logic                             call_arrival_n,
	output logic                             alert_tone_valid,
	output logic                             int_o,
	output logic                             int_oe
);
	import fsk_pkg::*;

	typedef struct packed {
		cd_e               cd;
		logic              cp_n;
		logic [CNT_W-1:0]  cd_cnt;
		logic              act_m;
		logic              act_s;
		logic              rclk_m;
		logic              rclk_s;
		logic              rclk_d;
		logic              arr_m;
		logic              arr_s;
		logic              est_m;
		logic              est_s;
		logic [CNT_W-1:0]  arr_cnt;
		logic [CNT_W-1:0]  tone_cnt;
		logic              tone_valid;
		logic              call_n;
		logic [WORD_W-1:0] asm_w;
		logic [2:0]        asm_cnt;
		logic [WORD_W-1:0] shreg;
		logic [3:0]        left;
		logic [WORD_W-1:0] word;
		logic              wr_n;
		logic [CNT_W-1:0]  wr_cnt;
		logic              data;
		logic              int_act;
		logic [2:0]        ctrl;
		logic [31:0]       rdata;
		logic              ready;
		logic              err;
	} st_s;

	localparam st_s ST_RST = '{
		cd: CD_OFF, cp_n: 1'b1, cd_cnt: '0, act_m: 1'b0, act_s: 1'b0,
		rclk_m: 1'b0, rclk_s: 1'b0, rclk_d: 1'b0,
		arr_m: 1'b0, arr_s: 1'b0, est_m: 1'b0, est_s: 1'b0,
		arr_cnt: '0, tone_cnt: '0, tone_valid: 1'b0, call_n: 1'b1,
		asm_w: '0, asm_cnt: '0, shreg: '0, left: '0, word: '0,
		wr_n: 1'b1, wr_cnt: '0, data: 1'b1, int_act: 1'b0,
		ctrl: CTRL_RST, rdata: '0, ready: 1'b0, err: 1'b0
	};

	st_s  s_r;
	st_s  s_nxt;
	logic rst_m_r;
	logic rst_n_r;
	logic active;
	logic enabled;
	logic mode_host;
	logic carrier_on;
	logic rclk_rise;

	fsk_link_if link ();

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// ------------------------------------------------------------
	// bit recovery
	// ------------------------------------------------------------
	fsk_bit_sampler #(
		.BIT_CYCLES  (BIT_CYCLES),
		.HALF_CYCLES (HALF_BIT_CYCLES)
	) u_sampler (
		.mclk      (mclk),
		.rst_n     (rst_n_r),
		.demod_bit (demod_bit),
		.bus       (link.sampler)
	);

	assign link.run = carrier_on;

	assign active = ~s_r.ctrl[CTRL_POWER_DOWN_IN];
	assign enabled = active & s_r.ctrl[CTRL_DEMOD];
	assign mode_host = s_r.ctrl[CTRL_MODE];
	assign carrier_on = (s_r.cd == CD_ON);
	assign rclk_rise = s_r.rclk_s & ~s_r.rclk_d;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.act_m = band_activity;
		s_nxt.act_s = s_r.act_m;
		s_nxt.rclk_m = host_read_clock;
		s_nxt.rclk_s = s_r.rclk_m;
		s_nxt.rclk_d = s_r.rclk_s;
		s_nxt.arr_m = arrival_sense_in;
		s_nxt.arr_s = s_r.arr_m;
		s_nxt.est_m = alert_tone_early;
		s_nxt.est_s = s_r.est_m;

		// ------------------------------------------------------------
		// carrier qualifier
		// ------------------------------------------------------------
		case (s_r.cd)
			CD_OFF: begin
				s_nxt.cd_cnt = '0;
				if (s_r.act_s) begin
					s_nxt.cd = CD_QUAL;
				end
			end
			CD_QUAL: begin
				if (!s_r.act_s) begin
					s_nxt.cd = CD_OFF;
					s_nxt.cd_cnt = '0;
				end else if (s_r.cd_cnt == CNT_W'(CD_QUAL_CYCLES - 1)) begin
					s_nxt.cd = CD_ON;
					s_nxt.cd_cnt = '0;
				end else begin
					s_nxt.cd_cnt = s_r.cd_cnt + CNT_W'(1);
				end
			end
			CD_ON: begin
				if (s_r.act_s) begin
					s_nxt.cd_cnt = '0;
				end else if (s_r.cd_cnt == CNT_W'(CD_HOLD_CYCLES - 1)) begin
					s_nxt.cd = CD_OFF;
					s_nxt.cd_cnt = '0;
				end else begin
					s_nxt.cd_cnt = s_r.cd_cnt + CNT_W'(1);
				end
			end
			default: begin
				s_nxt.cd = CD_OFF;
				s_nxt.cd_cnt = '0;
			end
		endcase
		if (!enabled) begin
			s_nxt.cd = CD_OFF;
			s_nxt.cd_cnt = '0;
		end
		s_nxt.cp_n = (s_nxt.cd != CD_ON);

		// ------------------------------------------------------------
		// word ready timeout or first read pulse
		// ------------------------------------------------------------
		if (!s_r.wr_n) begin
			if (rclk_rise) begin
				s_nxt.wr_n = 1'b1;
			end else if (s_r.wr_cnt == CNT_W'(HALF_BIT_CYCLES - 1)) begin
				s_nxt.wr_n = 1'b1;
			end else begin
				s_nxt.wr_cnt = s_r.wr_cnt + CNT_W'(1);
			end
		end

		// host read shifting
		if (mode_host && rclk_rise && (s_r.left != 4'h0)) begin
			s_nxt.data = s_r.shreg[0];
			s_nxt.shreg = {1'b0, s_r.shreg[WORD_W-1:1]};
			s_nxt.left = s_r.left - 4'h1;
		end

		// word assembly, only with carrier present
		if (!carrier_on) begin
			s_nxt.asm_cnt = '0;
		end else if (mode_host && link.sample_stb) begin
			s_nxt.asm_w = {link.sample_bit, s_r.asm_w[WORD_W-1:1]};
			if (s_r.asm_cnt == 3'h7) begin
				s_nxt.asm_cnt = '0;
				s_nxt.shreg = {link.sample_bit, s_r.asm_w[WORD_W-1:1]};
				s_nxt.word = {link.sample_bit, s_r.asm_w[WORD_W-1:1]};
				s_nxt.left = 4'h8;
				s_nxt.wr_n = 1'b0;
				s_nxt.wr_cnt = '0;
			end else begin
				s_nxt.asm_cnt = s_r.asm_cnt + 3'h1;
			end
		end

		// device initiated mode
		if (!mode_host) begin
			s_nxt.left = 4'h0;
			s_nxt.data = carrier_on ? link.raw_bit : 1'b1;
		end

		// ------------------------------------------------------------
		// power down keeps only the arrival path
		// ------------------------------------------------------------
		if (!active) begin
			s_nxt.wr_n = 1'b1;
			s_nxt.left = 4'h0;
			s_nxt.asm_cnt = '0;
		end

		// ------------------------------------------------------------
		// call arrival with envelope stretch
		// ------------------------------------------------------------
		if (s_r.arr_s) begin
			s_nxt.call_n = 1'b0;
			s_nxt.arr_cnt = '0;
		end else if (!s_r.call_n) begin
			if (s_r.arr_cnt == CNT_W'(ARR_HOLD_CYCLES - 1)) begin
				s_nxt.call_n = 1'b1;
				s_nxt.arr_cnt = '0;
			end else begin
				s_nxt.arr_cnt = s_r.arr_cnt + CNT_W'(1);
			end
		end

		// ------------------------------------------------------------
		// tone valid with guard qualification
		// ------------------------------------------------------------
		if (!active) begin
			s_nxt.tone_valid = 1'b0;
			s_nxt.tone_cnt = '0;
		end else if (s_r.est_s == s_r.tone_valid) begin
			s_nxt.tone_cnt = '0;
		end else if (s_r.tone_cnt == CNT_W'(TONE_GUARD_CYCLES - 1)) begin
			s_nxt.tone_valid = s_r.est_s;
			s_nxt.tone_cnt = '0;
		end else begin
			s_nxt.tone_cnt = s_r.tone_cnt + CNT_W'(1);
		end

		s_nxt.int_act = ~s_nxt.call_n | s_nxt.tone_valid | ~s_nxt.wr_n;

		// ------------------------------------------------------------
		// apb slave, one wait free access phase
		// ------------------------------------------------------------
		s_nxt.ready = 1'b0;
		s_nxt.err = 1'b0;
		if (psel && !penable) begin
			s_nxt.ready = 1'b1;
			case (paddr)
				OFF_CTRL: begin
					s_nxt.rdata = {29'h0, s_r.ctrl};
				end
				OFF_STATUS: begin
					s_nxt.rdata = {26'h0, s_r.left != 4'h0, s_r.int_act, s_r.tone_valid,
						s_r.call_n, s_r.wr_n, ~carrier_on};
				end
				OFF_WORD: begin
					s_nxt.rdata = {24'h0, s_r.word};
				end
				default: begin
					s_nxt.rdata = '0;
					s_nxt.err = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_r.ready && pwrite && (paddr == OFF_CTRL)) begin
			s_nxt.ctrl = pwdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.err;
	assign serial_data = s_r.data;
	assign word_ready_n = s_r.wr_n;
	assign carrier_present_n = s_r.cp_n;
	assign call_arrival_n = s_r.call_n;
	assign alert_tone_valid = s_r.tone_valid;
	assign int_o = 1'b0;
	assign int_oe = s_r.int_act;
endmodule // fsk_word_output

// [hw/fsk_pkg.sv]
// shared constants, register map and state codes for the fsk word output block
package fsk_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CD_HOLD_US    = 8000;
	localparam int unsigned CD_QUAL_US    = 2000;
	localparam int unsigned HALF_BIT_HZ   = 2400;
	localparam int unsigned BAUD_HZ       = 1200;
	localparam int unsigned TONE_GUARD_US = 40000;
	localparam int unsigned ARR_HOLD_US   = 50000;
	localparam int unsigned CD_HOLD_CYC   = CD_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CD_QUAL_CYC   = CD_QUAL_US * (CLK_HZ / 1_000_000);
	localparam int unsigned HALF_BIT_CYC  = CLK_HZ / HALF_BIT_HZ;
	localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_HZ;
	localparam int unsigned TONE_GUARD_CYC = TONE_GUARD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned ARR_HOLD_CYC  = ARR_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W         = 21;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W     = 12;
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_WORD   = 12'h008;
	localparam logic [2:0]  CTRL_RST   = 3'h0;
	localparam int unsigned CTRL_MODE  = 0;
	localparam int unsigned CTRL_DEMOD = 1;
	localparam int unsigned CTRL_POWER_DOWN_IN  = 2;
	localparam int unsigned WORD_W     = 8;

	// ------------------------------------------------------------
	// carrier qualifier states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CD_OFF  = 3'b001,
		CD_QUAL = 3'b010,
		CD_ON   = 3'b100
	} cd_e;

endpackage

// [hw/fsk_link_if.sv]
// bit recovery link between the sampler and the word logic
`timescale 1ns/1ps
interface fsk_link_if;
	logic run;
	logic sample_stb;
	logic sample_bit;
	logic raw_bit;

	modport sampler (input run, output sample_stb, output sample_bit, output raw_bit);
	modport consumer (output run, input sample_stb, input sample_bit, input raw_bit);
endinterface

// [hw/fsk_bit_sampler.sv]
// recovers demodulated bits at the centre of each bit period
`timescale 1ns/1ps
module fsk_bit_sampler #(
	parameter int unsigned BIT_CYCLES  = fsk_pkg::BIT_CYC,
	parameter int unsigned HALF_CYCLES = fsk_pkg::HALF_BIT_CYC
) (
	input  wire logic      mclk,
	input  wire logic      rst_n,
	input  wire logic      demod_bit,
	fsk_link_if.sampler    bus
);
	import fsk_pkg::*;

	typedef struct packed {
		logic             m;
		logic             sy;
		logic             d;
		logic [CNT_W-1:0] phase;
		logic             stb;
		logic             bit_v;
	} smp_s;

	smp_s s_r;
	smp_s s_nxt;

	// ------------------------------------------------------------
	// phase tracking
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.m = demod_bit;
		s_nxt.sy = s_r.m;
		s_nxt.d = s_r.sy;
		s_nxt.stb = 1'b0;
		// transitions realign the phase so sampling lands mid bit
		if (!bus.run || (s_r.sy != s_r.d)) begin
			s_nxt.phase = '0;
		end else if (s_r.phase == CNT_W'(BIT_CYCLES - 1)) begin
			s_nxt.phase = '0;
		end else begin
			s_nxt.phase = s_r.phase + CNT_W'(1);
		end
		if (bus.run && (s_r.phase == CNT_W'(HALF_CYCLES - 1))) begin
			s_nxt.stb = 1'b1;
			s_nxt.bit_v = s_r.sy;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.sample_stb = s_r.stb;
	assign bus.sample_bit = s_r.bit_v;
	assign bus.raw_bit = s_r.sy;
endmodule // fsk_bit_sampler

// [tb/fsk_word_output_chk.sv]
// concurrent checks on the fsk word output ports
`timescale 1ns/1ps
module fsk_word_output_chk #(
	parameter int unsigned CD_QUAL_CYCLES  = 20,
	parameter int unsigned CD_HOLD_CYCLES  = 50,
	parameter int unsigned HALF_BIT_CYCLES = 20
) (
	input wire logic                       mclk,
	input wire logic                       arst_n,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [fsk_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic                       pready,
	input wire logic                       band_activity,
	input wire logic                       host_read_clock,
	input wire logic                       arrival_sense_in,
	input wire logic                       serial_data,
	input wire logic                       word_ready_n,
	input wire logic                       carrier_present_n,
	input wire logic                       call_arrival_n,
	input wire logic                       alert_tone_valid,
	input wire logic                       int_oe
);
	import fsk_pkg::*;
	logic        mode_r, demod_r, power_down_in_r;
	logic [31:0] idle_r, act_r;

	// --------------------------------
	// control bits as written, band activity run lengths
	// --------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{mode_r, demod_r, power_down_in_r} <= 3'h0;
			idle_r <= 32'h0;
			act_r <= 32'h0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
				{power_down_in_r, demod_r, mode_r} <= pwdata[2:0];
			end
			idle_r <= band_activity ? 32'h0 : idle_r + 32'h1;
			act_r <= band_activity ? act_r + 32'h1 : 32'h0;
		end
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	property p_int;
		int_oe == (!call_arrival_n || alert_tone_valid || !word_ready_n);
	endproperty
	a_int: assert property (p_int) else $error("interrupt does not follow sources");
	property p_ans;
		psel && !penable |=> pready;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer after setup");
	property p_qual;
		$fell(carrier_present_n) |-> act_r >= CD_QUAL_CYCLES;
	endproperty
	a_qual: assert property (p_qual) else $error("carrier before qualification");
	property p_hold;
		!carrier_present_n && demod_r && !power_down_in_r && !psel && idle_r < CD_HOLD_CYCLES |=> !carrier_present_n;
	endproperty
	a_hold: assert property (p_hold) else $error("carrier dropped early");
	property p_rel;
		idle_r == CD_HOLD_CYCLES + 8 |-> carrier_present_n;
	endproperty
	a_rel: assert property (p_rel) else $error("carrier not released");
	property p_gate;
		!mode_r && !$past(mode_r) && carrier_present_n && $past(carrier_present_n) |-> serial_data;
	endproperty
	a_gate: assert property (p_gate) else $error("data not high without carrier");
	property p_noload;
		$fell(word_ready_n) |-> !$past(carrier_present_n);
	endproperty
	a_noload: assert property (p_noload) else $error("word loaded without carrier");
	property p_half;
		$fell(word_ready_n) |-> ##[1:HALF_BIT_CYCLES] word_ready_n;
	endproperty
	a_half: assert property (p_half) else $error("ready held too long");
	property p_first;
		$rose(host_read_clock) && !word_ready_n |-> ##[1:5] word_ready_n;
	endproperty
	a_first: assert property (p_first) else $error("ready not cleared by read");
	property p_arr;
		arrival_sense_in |-> ##[1:4] !call_arrival_n;
	endproperty
	a_arr: assert property (p_arr) else $error("call arrival missed");
	property p_pd;
		power_down_in_r && $past(power_down_in_r, 3) |-> !alert_tone_valid;
	endproperty
	a_pd: assert property (p_pd) else $error("tone valid in power down");
endmodule // fsk_word_output_chk

bind fsk_word_output fsk_word_output_chk #(
	.CD_QUAL_CYCLES(CD_QUAL_CYCLES), .CD_HOLD_CYCLES(CD_HOLD_CYCLES), .HALF_BIT_CYCLES(HALF_BIT_CYCLES)
) chk (
	.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .band_activity(band_activity), .host_read_clock(host_read_clock),
	.arrival_sense_in(arrival_sense_in), .serial_data(serial_data), .word_ready_n(word_ready_n),
	.carrier_present_n(carrier_present_n), .call_arrival_n(call_arrival_n),
	.alert_tone_valid(alert_tone_valid), .int_oe(int_oe)
);

// [tb/host_reader.sv]
// host model that clocks words out of the serial port
`timescale 1ns/1ps
module host_reader (
	input  wire logic       mclk,
	input  wire logic       en,
	input  wire logic [3:0] pulses,
	input  wire logic       word_ready_n,
	input  wire logic       serial_data,
	output logic            host_read_clock,
	output logic [7:0]      word,
	output logic [7:0]      words
);
	logic [7:0] sh;

	initial begin
		host_read_clock = 1'b0;
		word = 8'h00;
		words = 8'h00;
	end

	// read clock runs only while a word is being read, 450 ns period
	always @(negedge word_ready_n) begin
		if (en) begin
			for (int i = 0; i < pulses; i++) begin
				@(posedge mclk);
				host_read_clock <= 1'b1;
				repeat (4) @(posedge mclk);
				host_read_clock <= 1'b0;
				repeat (4) @(posedge mclk);
				if (i < 8) begin
					sh = {serial_data, sh[7:1]};
				end
			end
			word <= sh;
			words <= words + 8'h01;
		end
	end
endmodule // host_reader

// [tb/fsk_word_output_test.sv]
// self-checking bench for the fsk word output block
`timescale 1ns/1ps
`define CHK(n, x, a) begin cmp_count++; if ((a) !== (x)) begin miscompares++; $display("MISMATCH %s expected %0h seen %0h", n, x, a); end end
module fsk_word_output_test;
	import fsk_pkg::*;
	localparam int unsigned QC = 20;
	localparam int unsigned HC = 50;
	localparam int unsigned HB = 20;
	localparam int unsigned BC = 40;
	localparam logic [7:0]  TXB = 8'hA5;
	logic        mclk = 1'b0;
	logic        arst_n, psel, penable, pwrite, pready, pslverr, e, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        demod_bit, band_activity, host_read_clock, arrival_sense_in, alert_tone_early;
	logic        serial_data, word_ready_n, carrier_present_n, call_arrival_n, alert_tone_valid, int_o, int_oe;
	logic        rd_en;
	logic [3:0]  rd_pulses;
	logic [7:0]  rd_word, rd_words;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          i;

	always #25 mclk = ~mclk;

	fsk_word_output #(.CD_QUAL_CYCLES(QC), .CD_HOLD_CYCLES(HC), .HALF_BIT_CYCLES(HB), .BIT_CYCLES(BC),
		.TONE_GUARD_CYCLES(30), .ARR_HOLD_CYCLES(30)) dut (
		.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .demod_bit(demod_bit),
		.band_activity(band_activity), .host_read_clock(host_read_clock), .arrival_sense_in(arrival_sense_in),
		.alert_tone_early(alert_tone_early), .serial_data(serial_data), .word_ready_n(word_ready_n),
		.carrier_present_n(carrier_present_n), .call_arrival_n(call_arrival_n),
		.alert_tone_valid(alert_tone_valid), .int_o(int_o), .int_oe(int_oe));

	host_reader host (.mclk(mclk), .en(rd_en), .pulses(rd_pulses), .word_ready_n(word_ready_n),
		.serial_data(serial_data), .host_read_clock(host_read_clock), .word(rd_word), .words(rd_words));

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_regs;
		apb(1'b0, OFF_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, r)
		apb(1'b1, OFF_CTRL, 32'h7);
		apb(1'b0, OFF_CTRL, 32'h0);
		`CHK("ctrl readback", 32'h7, r)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped error", 1'b1, e)
		apb(1'b1, OFF_CTRL, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_mode0;
		band_activity <= 1'b1;
		cyc(QC * 2);
		`CHK("carrier demod off", 1'b1, carrier_present_n)
		band_activity <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h2);
		demod_bit <= 1'b0;
		cyc(10);
		`CHK("data held high", 1'b1, serial_data)
		band_activity <= 1'b1;
		cyc(QC);
		`CHK("carrier early", 1'b1, carrier_present_n)
		cyc(10);
		`CHK("carrier on", 1'b0, carrier_present_n)
		`CHK("data zero", 1'b0, serial_data)
		demod_bit <= 1'b1;
		cyc(5);
		`CHK("data one", 1'b1, serial_data)
		band_activity <= 1'b0;
		demod_bit <= 1'b0;
		cyc(HC / 2);
		`CHK("carrier bridges", 1'b0, carrier_present_n)
		cyc(HC);
		`CHK("carrier released", 1'b1, carrier_present_n)
		`CHK("data forced high", 1'b1, serial_data)
		apb(1'b1, OFF_CTRL, 32'h4);
		$display("test mode0 done");
	endtask

	task automatic t_word;
		apb(1'b1, OFF_CTRL, 32'h3);
		seen = 1'b0;
		for (i = 0; i < 400; i++) begin
			@(posedge mclk);
			demod_bit <= i[3];
			seen |= !word_ready_n;
		end
		`CHK("no word without carrier", 1'b0, seen)
		demod_bit <= 1'b1;
		band_activity <= 1'b1;
		for (i = 0; i < 2000 && word_ready_n !== 1'b0; i++) @(posedge mclk);
		`CHK("ready low", 1'b0, word_ready_n)
		cyc(HB + 2);
		`CHK("ready expires", 1'b1, word_ready_n)
		rd_pulses <= 4'hA;
		rd_en <= 1'b1;
		for (i = 0; i < 8; i++) begin
			demod_bit <= TXB[i];
			cyc(BC);
		end
		demod_bit <= 1'b1;
		for (i = 0; i < 400 && rd_words === 8'h00; i++) @(posedge mclk);
		`CHK("word read", TXB, rd_word)
		`CHK("extra reads ignored", TXB[7], serial_data)
		apb(1'b0, OFF_WORD, 32'h0);
		`CHK("word register", {24'h0, TXB}, r)
		rd_en <= 1'b0;
		band_activity <= 1'b0;
		cyc(HC + 20);
		$display("test word done");
	endtask

	task automatic t_power;
		apb(1'b1, OFF_CTRL, 32'h4);
		arrival_sense_in <= 1'b1;
		alert_tone_early <= 1'b1;
		cyc(6);
		`CHK("arrival in power down", 1'b0, call_arrival_n)
		`CHK("int on arrival", 1'b1, int_oe)
		arrival_sense_in <= 1'b0;
		cyc(60);
		`CHK("arrival released", 1'b1, call_arrival_n)
		`CHK("tone low in power down", 1'b0, alert_tone_valid)
		`CHK("int released", 1'b0, int_oe)
		apb(1'b1, OFF_CTRL, 32'h0);
		cyc(60);
		`CHK("tone valid", 1'b1, alert_tone_valid)
		`CHK("int on tone", 1'b1, int_oe)
		`CHK("int drive level", 1'b0, int_o)
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK("status sources", 32'h0000001F, r)
		alert_tone_early <= 1'b0;
		cyc(60);
		`CHK("tone gone", 1'b0, alert_tone_valid)
		$display("test power done");
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		{arst_n, psel, penable, pwrite, band_activity, arrival_sense_in, alert_tone_early, rd_en} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		demod_bit = 1'b1;
		rd_pulses = 4'h8;
		cyc(10);
		arst_n <= 1'b1;
		cyc(3);
		t_regs();
		t_mode0();
		t_word();
		t_power();
		conclude();
	end

	initial begin
		#1_000_000;
		miscompares++;
		conclude();
	end
endmodule // fsk_word_output_test
